// ---- hw/cvnp_defines.svh ----
// constants for the compressed voice nibble port
`ifndef CVNP_DEFINES_SVH
`define CVNP_DEFINES_SVH
`define CVNP_NIB_W          4
`define CVNP_FRAME_BYTES    12
`define CVNP_FRAME_BYTES_BX 48
`define CVNP_NIB_PERIOD_US  106
`define CVNP_SYS_CLK_MHZ    125
`define CVNP_NIB_PERIOD_CYC (`CVNP_NIB_PERIOD_US * `CVNP_SYS_CLK_MHZ)
`define CVNP_PCM_W          16
`define CVNP_CNT_W          7
`endif

// ---- hw/cvnp_pkg.sv ----
// types shared by the compressed voice nibble port
package cvnp_pkg;
	typedef struct packed {
		logic       valid;
		logic [3:0] data;
	} cvnp_nib_t;
	typedef enum {CVNP_IDLE, CVNP_ARMED, CVNP_RUN} cvnp_enc_state_t;
endpackage : cvnp_pkg

// ---- hw/cvnp_sync_edge.sv ----
// two-flop synchroniser with rise and fall pulses
`timescale 1ns/100ps
`default_nettype none
module cvnp_sync_edge (
	// clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_rst,
	// async level in, pulses out
	input  wire logic i_async,
	output logic      o_level,
	output logic      o_rise,
	output logic      o_fall
);
	logic meta_ff, sync_ff, prev_ff;
	logic nxt_meta, nxt_sync, nxt_prev;

	always_comb begin
		nxt_meta = i_async;
		nxt_sync = meta_ff;
		nxt_prev = sync_ff;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			prev_ff <= nxt_prev;
		end
	end

	assign o_level = sync_ff;
	assign o_rise  = sync_ff & ~prev_ff;
	assign o_fall  = ~sync_ff & prev_ff;
endmodule : cvnp_sync_edge
`default_nettype wire

// ---- hw/cvnp_port.sv ----
// compressed voice nibble port with pcm tdm side path
// What this block does
// - inbound nibbles captured then held in two-stage latch for processor read
// - outbound nibble driven onto pins at encoder clock rising edge
// - inbound nibble captured at decoder clock falling edge
// - frame-enable control sampled with nibble clock, same timing as data
// - encoder clock falling edge raises transmit nibble service pulse
// - decoder clock falling edge raises receive nibble service pulse
// - each transmit service loads next outbound nibble before next falling edge latches it
// - receive service reads nibble; full frame starts decoder stage at once
// - encoder frame start aligned to configuration and sampled frame enable
// - pcm data driven or sampled only while frame sync slot active
// - frame is 12 bytes, 48 bytes in bit-exact mode
`timescale 1ns/100ps
`default_nettype none
`include "cvnp_defines.svh"
module cvnp_port
	import cvnp_pkg::*;
#(
	parameter int NIB_W   = `CVNP_NIB_W,
	parameter int PCM_W   = `CVNP_PCM_W
) (
	// clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst,
	// configuration
	input  wire logic             i_bit_exact,
	input  wire logic             i_enc_enable,
	// host nibble pins
	input  wire logic             i_encoder_nibble_clock,
	input  wire logic             i_decoder_nibble_clock,
	input  wire logic             i_voice_frame_enable,
	input  wire logic [NIB_W-1:0] i_rx_nibble,
	output logic      [NIB_W-1:0] o_tx_nibble,
	// processor side
	input  wire logic [NIB_W-1:0] i_tx_data,
	output logic                  o_transmit_nibble_service,
	output logic                  o_receive_nibble_service,
	output logic      [NIB_W-1:0] o_rx_data,
	output logic                  o_encoder_stage,
	output logic                  o_decoder_stage,
	output logic                  o_frame_enable,
	// pcm tdm pins
	input  wire logic             i_pcm_clk,
	input  wire logic             i_pcm_fsync,
	input  wire logic             i_pcm_din,
	output logic                  o_pcm_dout,
	output logic                  o_pcm_dout_oe,
	// pcm word side
	input  wire logic [PCM_W-1:0] i_pcm_tx_word,
	output logic      [PCM_W-1:0] o_pcm_rx_word,
	output logic                  o_pcm_rx_valid
);
	// refused at elaboration: struct carrier and bit counter are sized for these
	if (NIB_W != `CVNP_NIB_W) begin : g_bad_nib_w
		$error("nibble width must be four");
	end
	if (PCM_W < 2 || PCM_W > 32) begin : g_bad_pcm_w
		$error("pcm width out of range");
	end

	localparam int FRAME_NIBS    = 2 * `CVNP_FRAME_BYTES;
	localparam int FRAME_NIBS_BX = 2 * `CVNP_FRAME_BYTES_BX;

	// edges of the slow clocks; pins already pass two flops in the synchroniser
	logic enc_rise, enc_fall;
	logic dec_rise, dec_fall;
	logic fen_lvl, pck_rise, pck_fall, fs_lvl;
	logic din_s0_ff, din_s1_ff;
	logic [NIB_W-1:0] rxn_s0_ff, rxn_s1_ff;

	cvnp_sync_edge u_enc (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_async(i_encoder_nibble_clock),
		.o_level(), .o_rise(enc_rise), .o_fall(enc_fall));
	cvnp_sync_edge u_dec (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_async(i_decoder_nibble_clock),
		.o_level(), .o_rise(dec_rise), .o_fall(dec_fall));
	cvnp_sync_edge u_fen (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_async(i_voice_frame_enable),
		.o_level(fen_lvl), .o_rise(), .o_fall());
	cvnp_sync_edge u_pck (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_async(i_pcm_clk),
		.o_level(), .o_rise(pck_rise), .o_fall(pck_fall));
	cvnp_sync_edge u_pfs (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_async(i_pcm_fsync),
		.o_level(fs_lvl), .o_rise(), .o_fall());

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			din_s0_ff <= 1'b0;
			din_s1_ff <= 1'b0;
			rxn_s0_ff <= '0;
			rxn_s1_ff <= '0;
		end else begin
			din_s0_ff <= i_pcm_din;
			din_s1_ff <= din_s0_ff;
			rxn_s0_ff <= i_rx_nibble;
			rxn_s1_ff <= rxn_s0_ff;
		end
	end

	// nibble datapath state
	logic [NIB_W-1:0] tx_hold_ff, nxt_tx_hold;
	logic [NIB_W-1:0] tx_pin_ff, nxt_tx_pin;
	cvnp_nib_t        rx_stage_ff, nxt_rx_stage;
	logic [NIB_W-1:0] rx_out_ff, nxt_rx_out;
	logic             fen_ff, nxt_fen;
	logic             txs_ff, nxt_txs, rxs_ff, nxt_rxs;
	logic [`CVNP_CNT_W-1:0] rx_cnt_ff, nxt_rx_cnt, tx_cnt_ff, nxt_tx_cnt;
	logic             dec_go_ff, nxt_dec_go, enc_go_ff, nxt_enc_go;
	cvnp_enc_state_t  enc_st_ff, nxt_enc_st;
	logic [`CVNP_CNT_W-1:0] frame_last;

	assign frame_last = i_bit_exact ? `CVNP_CNT_W'(FRAME_NIBS_BX - 1)
		: `CVNP_CNT_W'(FRAME_NIBS - 1);

	always_comb begin
		nxt_tx_hold  = tx_hold_ff;
		nxt_tx_pin   = tx_pin_ff;
		nxt_rx_stage = rx_stage_ff;
		nxt_rx_out   = rx_out_ff;
		nxt_fen      = fen_ff;
		nxt_txs      = enc_fall;
		nxt_rxs      = dec_fall;
		nxt_rx_cnt   = rx_cnt_ff;
		nxt_tx_cnt   = tx_cnt_ff;
		nxt_dec_go   = 1'b0;
		nxt_enc_go   = 1'b0;
		nxt_enc_st   = enc_st_ff;
		if (enc_fall) begin
			nxt_tx_hold = i_tx_data;
			nxt_fen     = fen_lvl;
		end
		if (enc_rise)
			nxt_tx_pin = tx_hold_ff;
		if (dec_fall)
			nxt_rx_stage = '{valid: 1'b1, data: rxn_s1_ff};
		// second latch stage: processor sees stable word while next is captured
		if (rx_stage_ff.valid) begin
			nxt_rx_out       = rx_stage_ff.data;
			nxt_rx_stage.valid = dec_fall;
			if (rx_cnt_ff >= frame_last) begin
				nxt_rx_cnt = '0;
				nxt_dec_go = 1'b1;
			end else begin
				nxt_rx_cnt = rx_cnt_ff + `CVNP_CNT_W'(1);
			end
		end
		// encoder frame alignment on the sampled frame enable
		case (enc_st_ff)
			CVNP_IDLE: begin
				nxt_tx_cnt = '0;
				if (i_enc_enable && enc_fall && !fen_lvl)
					nxt_enc_st = CVNP_ARMED;
			end
			CVNP_ARMED: begin
				if (!i_enc_enable)
					nxt_enc_st = CVNP_IDLE;
				else if (enc_fall && fen_lvl) begin
					nxt_enc_st = CVNP_RUN;
					nxt_enc_go = 1'b1;
					// start fall is nibble zero, so every frame spans the same count
					nxt_tx_cnt = '0;
				end
			end
			CVNP_RUN: begin
				if (!i_enc_enable)
					nxt_enc_st = CVNP_IDLE;
				else if (enc_fall) begin
					if (tx_cnt_ff >= frame_last) begin
						nxt_tx_cnt = '0;
						if (fen_lvl)
							nxt_enc_go = 1'b1;
						else
							nxt_enc_st = CVNP_ARMED;
					end else begin
						nxt_tx_cnt = tx_cnt_ff + `CVNP_CNT_W'(1);
					end
				end
			end
			default: nxt_enc_st = CVNP_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			tx_hold_ff  <= '0;
			tx_pin_ff   <= '0;
			rx_stage_ff <= '0;
			rx_out_ff   <= '0;
			fen_ff      <= 1'b0;
			txs_ff      <= 1'b0;
			rxs_ff      <= 1'b0;
			rx_cnt_ff   <= '0;
			tx_cnt_ff   <= '0;
			dec_go_ff   <= 1'b0;
			enc_go_ff   <= 1'b0;
			enc_st_ff   <= CVNP_IDLE;
		end else begin
			tx_hold_ff  <= nxt_tx_hold;
			tx_pin_ff   <= nxt_tx_pin;
			rx_stage_ff <= nxt_rx_stage;
			rx_out_ff   <= nxt_rx_out;
			fen_ff      <= nxt_fen;
			txs_ff      <= nxt_txs;
			rxs_ff      <= nxt_rxs;
			rx_cnt_ff   <= nxt_rx_cnt;
			tx_cnt_ff   <= nxt_tx_cnt;
			dec_go_ff   <= nxt_dec_go;
			enc_go_ff   <= nxt_enc_go;
			enc_st_ff   <= nxt_enc_st;
		end
	end

	// pcm tdm side path: shift only within the frame sync slot
	logic [PCM_W-1:0] ptx_sh_ff, nxt_ptx_sh, prx_sh_ff, nxt_prx_sh, prx_word_ff, nxt_prx_word;
	logic [5:0]       pbit_ff, nxt_pbit;
	logic             pdout_ff, nxt_pdout, poe_ff, nxt_poe, pvalid_ff, nxt_pvalid;
	logic             pact_ff, nxt_pact;

	always_comb begin
		nxt_ptx_sh   = ptx_sh_ff;
		nxt_prx_sh   = prx_sh_ff;
		nxt_prx_word = prx_word_ff;
		nxt_pbit     = pbit_ff;
		nxt_pdout    = pdout_ff;
		nxt_poe      = poe_ff;
		nxt_pvalid   = 1'b0;
		nxt_pact     = pact_ff;
		if (!fs_lvl) begin
			nxt_poe  = 1'b0;
			nxt_pact = 1'b0;
			nxt_pbit = '0;
			nxt_ptx_sh = i_pcm_tx_word;
		end else if (pck_rise) begin
			// drive on rising edge, far end samples on falling
			nxt_pdout  = ptx_sh_ff[PCM_W-1];
			nxt_ptx_sh = {ptx_sh_ff[PCM_W-2:0], 1'b0};
			nxt_poe    = (pbit_ff < 6'(PCM_W));
			nxt_pact   = 1'b1;
		end else if (pck_fall && pact_ff && pbit_ff < 6'(PCM_W)) begin
			nxt_prx_sh = {prx_sh_ff[PCM_W-2:0], din_s1_ff};
			nxt_pbit   = pbit_ff + 6'd1;
			if (pbit_ff == 6'(PCM_W - 1)) begin
				nxt_prx_word = {prx_sh_ff[PCM_W-2:0], din_s1_ff};
				nxt_pvalid   = 1'b1;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			ptx_sh_ff   <= '0;
			prx_sh_ff   <= '0;
			prx_word_ff <= '0;
			pbit_ff     <= '0;
			pdout_ff    <= 1'b0;
			poe_ff      <= 1'b0;
			pvalid_ff   <= 1'b0;
			pact_ff     <= 1'b0;
		end else begin
			ptx_sh_ff   <= nxt_ptx_sh;
			prx_sh_ff   <= nxt_prx_sh;
			prx_word_ff <= nxt_prx_word;
			pbit_ff     <= nxt_pbit;
			pdout_ff    <= nxt_pdout;
			poe_ff      <= nxt_poe;
			pvalid_ff   <= nxt_pvalid;
			pact_ff     <= nxt_pact;
		end
	end

	assign o_tx_nibble               = tx_pin_ff;
	assign o_transmit_nibble_service = txs_ff;
	assign o_receive_nibble_service  = rxs_ff;
	assign o_rx_data                 = rx_out_ff;
	assign o_encoder_stage           = enc_go_ff;
	assign o_decoder_stage           = dec_go_ff;
	assign o_frame_enable            = fen_ff;
	assign o_pcm_dout                = pdout_ff;
	assign o_pcm_dout_oe             = poe_ff;
	assign o_pcm_rx_word             = prx_word_ff;
	assign o_pcm_rx_valid            = pvalid_ff;
endmodule : cvnp_port
`default_nettype wire

// ---- verification/cvnp_port_sva.sv ----
// assertions on the ports of the compressed voice nibble port
`timescale 1ns/100ps
`default_nettype none
module cvnp_port_sva #(
	parameter int NIB_W = 4
) (
	// clock, reset, configuration and host pins
	input wire logic             i_sys_clk,
	input wire logic             i_rst,
	input wire logic             i_bit_exact,
	input wire logic             i_enc_enable,
	input wire logic             i_encoder_nibble_clock,
	input wire logic             i_decoder_nibble_clock,
	input wire logic             i_voice_frame_enable,
	input wire logic             i_pcm_fsync,
	// design outputs
	input wire logic [NIB_W-1:0] o_tx_nibble,
	input wire logic [NIB_W-1:0] o_rx_data,
	input wire logic             o_transmit_nibble_service,
	input wire logic             o_receive_nibble_service,
	input wire logic             o_encoder_stage,
	input wire logic             o_decoder_stage,
	input wire logic             o_frame_enable,
	input wire logic             o_pcm_dout_oe
);
	logic [6:0] rx_cnt_ff;
	logic [6:0] nxt_rx_cnt;
	logic [6:0] last_nib;
	assign last_nib = i_bit_exact ? 7'h5F : 7'h17;
	always_comb begin
		nxt_rx_cnt = rx_cnt_ff;
		if (o_receive_nibble_service)
			nxt_rx_cnt = (rx_cnt_ff == last_nib) ? 7'h00 : rx_cnt_ff + 7'h01;
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			rx_cnt_ff <= 7'h00;
		else
			rx_cnt_ff <= nxt_rx_cnt;
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	tx_svc_edge_a: assert property ($fell(i_encoder_nibble_clock) |->
		##[2:4] o_transmit_nibble_service) else $error("tx service missing");
	rx_svc_edge_a: assert property ($fell(i_decoder_nibble_clock) |->
		##[2:4] o_receive_nibble_service) else $error("rx service missing");
	rx_hold_a: assert property (!$past(o_receive_nibble_service) |->
		$stable(o_rx_data)) else $error("rx data moved off a service");
	tx_launch_a: assert property ($changed(o_tx_nibble) |->
		$past(i_encoder_nibble_clock, 2)) else $error("tx nibble moved off a rise");
	fe_sample_a: assert property ($changed(o_frame_enable) |->
		!$past(i_encoder_nibble_clock, 2)) else $error("frame enable moved off a fall");
	dec_frame_a: assert property (o_receive_nibble_service && rx_cnt_ff == last_nib
		|-> ##1 o_decoder_stage) else $error("decoder start missing");
	dec_only_a: assert property (o_decoder_stage |->
		$past(o_receive_nibble_service) && rx_cnt_ff == 7'h00) else $error("early decoder start");
	enc_start_a: assert property (o_encoder_stage |->
		i_enc_enable && $past(i_voice_frame_enable, 3)) else $error("encoder start unaligned");
	pcm_slot_a: assert property (!i_pcm_fsync [*8] |=>
		!o_pcm_dout_oe) else $error("pcm driven outside slot");
endmodule : cvnp_port_sva
bind cvnp_port cvnp_port_sva #(.NIB_W(NIB_W)) i_cvnp_port_sva (.*);
`default_nettype wire

// ---- verification/cvnp_host_model.sv ----
// host side model: nibble clocks, inbound nibbles and the pcm slot
`timescale 1ns/100ps
`default_nettype none
module cvnp_host_model (
	// run controls
	input  wire logic i_enc_run,
	input  wire logic i_dec_run,
	input  wire logic i_pcm_run,
	// host pins
	output logic       o_enc_clk = 1'b0,
	output logic       o_dec_clk = 1'b0,
	output logic [3:0] o_rx_nibble = 4'h0,
	output logic       o_pcm_clk = 1'b0,
	output logic       o_pcm_fsync = 1'b0,
	output logic       o_pcm_din = 1'b0
);
	localparam logic [15:0] PCM_PAT = 16'hA5C3;
	logic [3:0] nib_cnt = 4'hF;
	// clocks stand still low between frames
	always #40 if (i_enc_run || o_enc_clk) o_enc_clk = ~o_enc_clk;
	always #40 if (i_dec_run || o_dec_clk) o_dec_clk = ~o_dec_clk;
	always @(posedge o_dec_clk) begin
		nib_cnt = nib_cnt + 4'h1;
		o_rx_nibble = nib_cnt;
	end
	// hold time over: stale data must not look valid
	always @(negedge o_dec_clk) #30 o_rx_nibble = ~nib_cnt;
	always @(posedge i_pcm_run) begin
		o_pcm_fsync = 1'b1;
		#41;
		for (int k = 15; k >= 0; k--) begin
			o_pcm_clk = 1'b1;
			o_pcm_din = PCM_PAT[k];
			#40 o_pcm_clk = 1'b0;
			#40;
		end
		o_pcm_fsync = 1'b0;
		o_pcm_din = ~o_pcm_din;
	end
endmodule : cvnp_host_model
`default_nettype wire

// ---- verification/compressed_voice_nibble_port_tb.sv ----
// self-checking testbench for the compressed voice nibble port
`timescale 1ns/100ps
`default_nettype none
module compressed_voice_nibble_port_tb;
	logic        i_sys_clk, i_rst, i_bit_exact, i_enc_enable, fe, enc_run, dec_run, pcm_run;
	logic        enc_clk, dec_clk, pcm_clk, fsync, din, tx_svc, rx_svc, enc_stage, dec_stage;
	logic        frame_en, pcm_dout, pcm_oe, pcm_rx_valid;
	logic [3:0]  i_tx_data, rx_nib, tx_nib, rx_data;
	logic [3:0]  rx_exp = 4'hF;
	logic [15:0] i_pcm_tx_word, pcm_rx_word;
	int          fail_count = 0;
	int          n_tests = 0;
	int          n_enc = 0;
	cvnp_port i_cvnp_port (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_bit_exact(i_bit_exact),
		.i_enc_enable(i_enc_enable), .i_encoder_nibble_clock(enc_clk),
		.i_decoder_nibble_clock(dec_clk), .i_voice_frame_enable(fe), .i_rx_nibble(rx_nib),
		.o_tx_nibble(tx_nib), .i_tx_data(i_tx_data), .o_transmit_nibble_service(tx_svc),
		.o_receive_nibble_service(rx_svc), .o_rx_data(rx_data), .o_encoder_stage(enc_stage),
		.o_decoder_stage(dec_stage), .o_frame_enable(frame_en), .i_pcm_clk(pcm_clk),
		.i_pcm_fsync(fsync), .i_pcm_din(din), .o_pcm_dout(pcm_dout), .o_pcm_dout_oe(pcm_oe),
		.i_pcm_tx_word(i_pcm_tx_word), .o_pcm_rx_word(pcm_rx_word),
		.o_pcm_rx_valid(pcm_rx_valid));
	cvnp_host_model i_cvnp_host_model (.i_enc_run(enc_run), .i_dec_run(dec_run),
		.i_pcm_run(pcm_run), .o_enc_clk(enc_clk), .o_dec_clk(dec_clk), .o_rx_nibble(rx_nib),
		.o_pcm_clk(pcm_clk), .o_pcm_fsync(fsync), .o_pcm_din(din));
	initial begin
		i_sys_clk = 1'b0;
		forever #4 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) if (enc_stage === 1'b1) n_enc++;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	task automatic do_reset(input int n);
		i_rst <= 1'b1;
		repeat (n) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_sys_clk);
	endtask : do_reset
	// outbound stream with frame alignment; frame enable rises after the arming falls
	task automatic t_tx;
		logic [3:0] prev;
		i_enc_enable <= 1'b1;
		enc_run <= 1'b1;
		for (int k = 1; k <= 40; k++) begin
			@(posedge i_sys_clk iff tx_svc);
			if (k > 1) check(tx_nib, prev);
			check(enc_stage, k == 3 || k == 27);
			prev = i_tx_data;
			i_tx_data <= i_tx_data + 4'h3;
			if (k == 2) fe <= 1'b1;
			if (k == 31) fe <= 1'b0;
			if (k == 5) check(frame_en, 1'b1);
		end
		check(frame_en, 1'b0);
		check(16'(n_enc), 16'h0002);
		enc_run <= 1'b0;
		i_enc_enable <= 1'b0;
	endtask : t_tx
	// inbound frame; the clock is stopped right after the last service
	// decoder start shows in the same cycle as the frame's last nibble
	task automatic t_rx(input logic be);
		int n;
		n = be ? 96 : 24;
		i_bit_exact <= be;
		do_reset(2);
		dec_run <= 1'b1;
		for (int k = 0; k < n; k++) begin
			@(posedge i_sys_clk iff rx_svc);
			if (k == n - 1) dec_run <= 1'b0;
			rx_exp = rx_exp + 4'h1;
			@(posedge i_sys_clk);
			check(rx_data, rx_exp);
			check(dec_stage, k == n - 1);
		end
	endtask : t_rx
	task automatic t_pcm;
		logic [15:0] got;
		i_pcm_tx_word <= 16'h3C5A;
		@(posedge i_sys_clk);
		pcm_run <= 1'b1;
		repeat (16) begin
			@(negedge pcm_clk);
			got = {got[14:0], pcm_dout};
			check(pcm_oe, 1'b1);
		end
		@(posedge i_sys_clk iff pcm_rx_valid);
		check(pcm_rx_word, 16'hA5C3);
		check(got, 16'h3C5A);
		pcm_run <= 1'b0;
	endtask : t_pcm
	initial begin
		i_rst = 1'b1;
		{i_bit_exact, i_enc_enable, fe, enc_run, dec_run, pcm_run} = 6'h00;
		i_tx_data = 4'h5;
		i_pcm_tx_word = 16'h0000;
		do_reset(12);
		t_tx();
		t_rx(1'b0);
		t_rx(1'b1);
		t_pcm();
		report_and_stop();
	end
	// run needs about 2000 cycles
	initial begin
		#100000;
		fail_count++;
		report_and_stop();
	end
endmodule : compressed_voice_nibble_port_tb
`default_nettype wire
